//--- rtl/gcrb_cfg.svh
`ifndef GCRB_CFG_SVH
`define GCRB_CFG_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define GCRB_IDX_LAST      8'h2f
`define GCRB_IDX_CTRL      8'h02
`define GCRB_IDX_LDEV      8'h07
`define GCRB_IDX_DEVID     8'h20
`define GCRB_IDX_DEVREV    8'h21

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GCRB_CTRL_SRST_BIT 0
`define GCRB_LDEV_RST      8'h00
`define GCRB_INDEX_RST     8'h00
// arbitrary identity values, not tied to any real part
`define GCRB_DEVID_DEF     8'h5a
`define GCRB_DEVREV_DEF    8'h01

`endif

//--- rtl/gcrb_pkg.sv
package gcrb_pkg;
   typedef logic [7:0] gcrb_byte_t;

   typedef enum logic [1:0] {
      GCRB_SEL_NONE  = 2'b00,
      GCRB_SEL_CTRL  = 2'b01,
      GCRB_SEL_LDEV  = 2'b10,
      GCRB_SEL_RO    = 2'b11
   } gcrb_sel_t;
endpackage

//--- rtl/gcrb_decode.sv
`timescale 1ns/1ps
`include "gcrb_cfg.svh"

module gcrb_decode
   import gcrb_pkg::*;
#(
   parameter logic [7:0] DEV_ID  = `GCRB_DEVID_DEF,
   parameter logic [7:0] DEV_REV = `GCRB_DEVREV_DEF
) (
   // index in
   input  wire gcrb_pkg::gcrb_byte_t index,
   // decode out
   output gcrb_pkg::gcrb_sel_t       sel,
   output gcrb_pkg::gcrb_byte_t      ro_data
);
   import gcrb_pkg::*;

   // full 8-bit compare, no aliasing
   always_comb begin
      sel     = GCRB_SEL_NONE;
      ro_data = 8'h00;
      unique case (index)
         `GCRB_IDX_CTRL:   sel = GCRB_SEL_CTRL;
         `GCRB_IDX_LDEV:   sel = GCRB_SEL_LDEV;
         `GCRB_IDX_DEVID: begin
            sel     = GCRB_SEL_RO;
            ro_data = DEV_ID;
         end
         `GCRB_IDX_DEVREV: begin
            sel     = GCRB_SEL_RO;
            ro_data = DEV_REV;
         end
         default:          sel = GCRB_SEL_NONE;
      endcase
   end
endmodule

//--- rtl/gcrb_top.sv
`timescale 1ns/1ps
`include "gcrb_cfg.svh"

module gcrb_top
   import gcrb_pkg::*;
#(
   parameter logic [7:0] DEV_ID  = `GCRB_DEVID_DEF,
   parameter logic [7:0] DEV_REV = `GCRB_DEVREV_DEF
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   // configuration mode level
   input  wire logic                 cfg_mode,
   // index/data port
   input  wire logic                 index_wr,
   input  wire logic                 data_wr,
   input  wire logic                 data_rd,
   input  wire gcrb_pkg::gcrb_byte_t wr_data,
   output gcrb_pkg::gcrb_byte_t      rd_data,
   output gcrb_pkg::gcrb_byte_t      index_out,
   // to logical device registers
   output gcrb_pkg::gcrb_byte_t      ldev_sel,
   output logic                      soft_rst,
   output logic                      ldev_access
);
   import gcrb_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_b_int;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_b_int = rst_sync_q[1];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      gcrb_byte_t index;
      gcrb_byte_t ldev;
      gcrb_byte_t rdata;
      logic       srst;
      logic       lacc;
   } gcrb_state_t;

   gcrb_state_t st_q;
   gcrb_state_t st_d;
   gcrb_sel_t   sel;
   gcrb_byte_t  ro_data;

   gcrb_decode #(
      .DEV_ID  (DEV_ID),
      .DEV_REV (DEV_REV)
   ) gcrb_decode_inst (
      .index   (st_q.index),
      .sel     (sel),
      .ro_data (ro_data)
   );

   // in-range check kept separate so the upper map stays outside this block
   function automatic logic gcrb_global(input gcrb_byte_t idx);
      gcrb_global = (idx <= `GCRB_IDX_LAST);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d       = st_q;
      st_d.srst  = 1'b0;
      st_d.lacc  = 1'b0;
      st_d.rdata = 8'h00;
      if (cfg_mode) begin
         if (index_wr) begin
            st_d.index = wr_data;
         end
         if (data_wr && gcrb_global(st_q.index)) begin
            if (sel == GCRB_SEL_CTRL) begin
               st_d.srst = wr_data[`GCRB_CTRL_SRST_BIT];
            end else if (sel == GCRB_SEL_LDEV) begin
               st_d.ldev = wr_data;
            end
         end
         if (data_rd && gcrb_global(st_q.index)) begin
            unique case (sel)
               GCRB_SEL_LDEV: st_d.rdata = st_q.ldev;
               GCRB_SEL_RO:   st_d.rdata = ro_data;
               GCRB_SEL_CTRL: st_d.rdata = 8'h00;
               GCRB_SEL_NONE: st_d.rdata = 8'h00;
            endcase
         end
         // accesses above the global range go to the selected device only
         if ((data_wr || data_rd) && !gcrb_global(st_q.index)) begin
            st_d.lacc = 1'b1;
         end
      end
      // soft reset returns the device select to its default
      if (st_q.srst) begin
         st_d.ldev = `GCRB_LDEV_RST;
      end
   end

   always_ff @(posedge clock or negedge rst_b_int) begin
      if (!rst_b_int) begin
         st_q.index <= `GCRB_INDEX_RST;
         st_q.ldev  <= `GCRB_LDEV_RST;
         st_q.rdata <= 8'h00;
         st_q.srst  <= 1'b0;
         st_q.lacc  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data     = st_q.rdata;
   assign index_out   = st_q.index;
   assign ldev_sel    = st_q.ldev;
   assign soft_rst    = st_q.srst;
   assign ldev_access = st_q.lacc;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   soft_pulse_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      cfg_mode && data_wr && st_q.index == `GCRB_IDX_CTRL && wr_data[0]
      |=> soft_rst ##1 !soft_rst)
      else $error("soft reset pulse missing");
   srst_clear_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      soft_rst |=> !soft_rst)
      else $error("soft reset bit stuck");
   ldev_write_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      cfg_mode && data_wr && st_q.index == `GCRB_IDX_LDEV && !soft_rst
      |=> ldev_sel == $past(wr_data))
      else $error("device select not written");
   ldev_soft_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      soft_rst |=> ldev_sel == 8'h00)
      else $error("device select kept over soft reset");
   index_latch_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      cfg_mode && index_wr |=> index_out == $past(wr_data))
      else $error("index not latched");
   mode_gate_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      !cfg_mode |=> $stable(index_out) && rd_data == 8'h00 && !soft_rst)
      else $error("access outside configuration mode");
   id_read_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      cfg_mode && data_rd && !index_wr && index_out == `GCRB_IDX_DEVID
      |=> rd_data == DEV_ID)
      else $error("identification read wrong");
   rev_read_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      cfg_mode && data_rd && index_out == `GCRB_IDX_DEVREV
      |=> rd_data == DEV_REV)
      else $error("revision read wrong");
   resv_read_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      data_rd && index_out inside {[8'h00:8'h06], [8'h08:8'h1f], [8'h22:8'h2f]}
      |=> rd_data == 8'h00)
      else $error("reserved read not zero");
   no_alias_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      data_wr && index_out != `GCRB_IDX_LDEV && !soft_rst
      |=> $stable(ldev_sel))
      else $error("write aliased onto device select");
   dev_acc_a: assert property (@(posedge clock) disable iff (!rst_b_int)
      cfg_mode && data_wr && index_out > 8'h2f |=> ldev_access)
      else $error("device access not flagged");
endmodule

//--- verification/gcrb_bench.sv
`timescale 1ns/1ps
module global_config_register_bank_test;
   import gcrb_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   localparam gcrb_byte_t ID_V  = 8'h3c; // arbitrary identity value
   localparam gcrb_byte_t REV_V = 8'h07; // arbitrary identity value
   logic       clock = 1'b0;
   logic       rst_b = 1'b0;
   logic       cfg_mode = 1'b1;
   logic       index_wr = 1'b0;
   logic       data_wr = 1'b0;
   logic       data_rd = 1'b0;
   gcrb_byte_t wr_data = 8'h00;
   gcrb_byte_t rd_data, index_out, ldev_sel, v;
   logic       soft_rst, ldev_access;
   int         mismatches = 0;
   int         n_compared = 0;
   always #12.5 clock = ~clock;
   gcrb_top #(.DEV_ID(ID_V), .DEV_REV(REV_V)) gcrb_top_inst (
      .clock(clock), .rst_b(rst_b), .cfg_mode(cfg_mode), .index_wr(index_wr),
      .data_wr(data_wr), .data_rd(data_rd), .wr_data(wr_data), .rd_data(rd_data),
      .index_out(index_out), .ldev_sel(ldev_sel), .soft_rst(soft_rst),
      .ldev_access(ldev_access));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input gcrb_byte_t seen, input gcrb_byte_t exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one request taken at the second edge; outputs sampled just after it
   task automatic xfer(input logic iw, input logic dw, input logic dr, input gcrb_byte_t d);
      @(posedge clock);
      index_wr <= iw;
      data_wr  <= dw;
      data_rd  <= dr;
      wr_data  <= d;
      @(posedge clock);
      index_wr <= 1'b0;
      data_wr  <= 1'b0;
      data_rd  <= 1'b0;
      #1;
   endtask
   task automatic wr_reg(input gcrb_byte_t idx, input gcrb_byte_t d);
      xfer(1'b1, 1'b0, 1'b0, idx);
      xfer(1'b0, 1'b1, 1'b0, d);
   endtask
   task automatic rd_reg(input gcrb_byte_t idx, output gcrb_byte_t r);
      xfer(1'b1, 1'b0, 1'b0, idx);
      xfer(1'b0, 1'b0, 1'b1, 8'h00);
      r = rd_data;
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_select();
      wr_reg(8'h07, 8'ha5);
      chk(index_out, 8'h07);
      chk(ldev_sel, 8'ha5);
      rd_reg(8'h07, v);
      chk(v, 8'ha5);
   endtask
   task automatic t_ident();
      wr_reg(8'h20, 8'hff);
      rd_reg(8'h20, v);
      chk(v, ID_V);
      wr_reg(8'h21, 8'h00);
      rd_reg(8'h21, v);
      chk(v, REV_V);
   endtask
   // bit0 clear must not reset; other bits of the command are unimplemented
   task automatic t_reserved();
      for (int i = 0; i < 48; i++) begin
         if (i != 2 && i != 7 && i != 32 && i != 33) begin
            wr_reg(8'(i), 8'hff);
            rd_reg(8'(i), v);
            chk(v, 8'h00);
         end
      end
      wr_reg(8'h02, 8'hfe);
      chk({7'h0, soft_rst}, 8'h00);
      rd_reg(8'h02, v);
      chk(v, 8'h00);
      chk(ldev_sel, 8'ha5);
   endtask
   // an index above the window must not alias onto device select
   task automatic t_alias();
      wr_reg(8'h87, 8'h5c);
      chk({7'h0, ldev_access}, 8'h01);
      chk(ldev_sel, 8'ha5);
      @(posedge clock);
      #1;
      chk({7'h0, ldev_access}, 8'h00);
   endtask
   task automatic t_mode();
      @(posedge clock);
      cfg_mode <= 1'b0;
      wr_reg(8'h07, 8'h11);
      chk(index_out, 8'h87);
      chk(ldev_sel, 8'ha5);
      rd_reg(8'h20, v);
      chk(v, 8'h00);
      @(posedge clock);
      cfg_mode <= 1'b1;
   endtask
   task automatic t_soft();
      wr_reg(8'h02, 8'h01);
      chk({7'h0, soft_rst}, 8'h01);
      @(posedge clock);
      #1;
      chk({7'h0, soft_rst}, 8'h00);
      chk(ldev_sel, 8'h00);
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      chk(ldev_sel, 8'h00);
      chk(rd_data, 8'h00);
      repeat (3) @(posedge clock);
      t_select();
      t_ident();
      t_reserved();
      t_alias();
      t_mode();
      t_soft();
      tally_and_finish();
   end
   initial begin
      repeat (4000) @(posedge clock);
      mismatches++;
      tally_and_finish();
   end
endmodule
